// ### hdl/jac_pkg.sv
// Shared constants for the actuator command port: timing, group numbers,
// node name, control frame field layout and the software register map.
// Assumes a 10 MHz system clock; all cycle counts derive from it.
package jac_pkg;

	// Clock rate and timing figures
	localparam int CLK_KHZ   = 10000;
	localparam int SLEEP_MS  = 5000;
	localparam int TRIP_MS   = 50;
	localparam int START_MS  = 100;
	localparam int WAKE_MS   = 10;
	localparam int CLAIM_MS  = 250;
	localparam int SLEEP_CYC = SLEEP_MS * CLK_KHZ;
	localparam int TRIP_CYC  = TRIP_MS * CLK_KHZ;
	localparam int START_CYC = START_MS * CLK_KHZ;
	localparam int WAKE_CYC  = WAKE_MS * CLK_KHZ;
	localparam int CLAIM_CYC = CLAIM_MS * CLK_KHZ;
	localparam int TMR_W     = 26;

	// Parameter group numbers, 18 bits: ext data page, data page, format, specific
	localparam logic [17:0] PGN_PROP_A     = 18'h0ef00;
	localparam logic [17:0] PGN_PROP_A2    = 18'h1ef00;
	localparam logic [17:0] PGN_ADDR_CLAIM = 18'h0ee00;
	localparam logic [17:0] PGN_CMD_ADDR   = 18'h0fed8;
	localparam logic [7:0]  PDU2_FIRST     = 8'hf0;
	localparam logic [2:0]  PRIO_CLAIM     = 3'h6;
	localparam logic [2:0]  PRIO_FB        = 3'h6;

	// Addresses
	localparam logic [7:0] DEF_ADDR    = 8'h13;
	localparam logic [7:0] GLOBAL_ADDR = 8'hff;
	localparam logic [7:0] ARB_FIRST   = 8'h80;
	localparam logic [7:0] ARB_LAST    = 8'hf7;

	// Node name fields; maker code and identity number are arbitrary values
	localparam logic        NAME_AAC       = 1'h1;
	localparam logic [2:0]  NAME_IND_GRP   = 3'h0;
	localparam logic [3:0]  NAME_VS_INST   = 4'h0;
	localparam logic [6:0]  NAME_VS        = 7'h00;
	localparam logic        NAME_RSVD      = 1'h0;
	localparam logic [7:0]  NAME_FUNC      = 8'hff;
	localparam logic [4:0]  NAME_FUNC_INST = 5'h00;
	localparam logic [2:0]  NAME_ECU_INST  = 3'h0;
	localparam logic [10:0] NAME_MAKER     = 11'h3a5;
	localparam logic [20:0] NAME_IDENT     = 21'h0a5c3;
	localparam logic [63:0] NODE_NAME = {NAME_AAC, NAME_IND_GRP, NAME_VS_INST, NAME_VS, NAME_RSVD,
		NAME_FUNC, NAME_FUNC_INST, NAME_ECU_INST, NAME_MAKER, NAME_IDENT};

	// Control frame layout, byte 1 bit 1 is bit 0
	localparam int POS_LSB = 0;
	localparam int POS_W   = 14;
	localparam int CUR_LSB = 14;
	localparam int CUR_W   = 9;
	localparam int SPD_LSB = 23;
	localparam int SPD_W   = 5;
	localparam int EN_BIT  = 28;

	// Parameter limits in counts (0.1 mm, 0.1 A, 5 %)
	localparam logic [8:0]  CUR_MIN   = 9'h00a;
	localparam logic [8:0]  CUR_MAX12 = 9'h0fa;
	localparam logic [8:0]  CUR_MAX24 = 9'h07d;
	localparam logic [13:0] POS_MAX   = 14'h2710;
	localparam logic [4:0]  SPD_MAX   = 5'h14;
	localparam logic [4:0]  PWM_STEPS = 5'h14;
	localparam logic [13:0] DEADBAND  = 14'h0005;

	// Register map, byte addresses
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_CTRL   = 8'h08;
	localparam logic [7:0] REG_TARGET = 8'h0c;
	localparam int CTRL_SLEEP_EN = 0;
	localparam int CTRL_RECLAIM  = 1;

	// Group number carried by an identifier; PDU1 specific byte is a destination
	function automatic logic [17:0] pgn_of(input logic [28:0] id);
		return {id[25:16], (id[23:16] < PDU2_FIRST) ? 8'h00 : id[15:8]};
	endfunction

	// Identifier from priority, group number (with destination) and source
	function automatic logic [28:0] make_id(input logic [2:0] prio, input logic [17:0] pgn,
		input logic [7:0] sa);
		return {prio, pgn, sa};
	endfunction

endpackage

// ### hdl/jac_addr_claim.sv
// Address claim engine: claims, defends and moves the node's source address.
// Assumes one-cycle event pulses from the frame decoder in the parent.
`timescale 1ns/100ps
module jac_addr_claim #(
	parameter int unsigned CLAIM_CYCLES = jac_pkg::CLAIM_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start_i,
	input  wire logic [7:0]  base_addr_i,
	input  wire logic        rx_claim_i,
	input  wire logic [63:0] rx_name_i,
	input  wire logic        cmd_i,
	input  wire logic [7:0]  cmd_addr_i,
	output logic      [7:0]  addr_o,
	output logic             claimed_o,
	output logic             tx_req_o,
	output logic      [28:0] tx_id_o,
	output logic      [63:0] tx_data_o
);
	localparam int TW = jac_pkg::TMR_W;

	typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_DONE} jac_claim_e;

	jac_claim_e       state;
	logic [TW-1:0]    tmr;
	wire              we_win  = jac_pkg::NODE_NAME <= rx_name_i;
	wire              defend  = rx_claim_i && state != CL_IDLE;
	wire              lose    = defend && !we_win;
	wire              send    = start_i || cmd_i || defend;
	wire  [7:0]       arb_nxt = (addr_o < jac_pkg::ARB_FIRST || addr_o >= jac_pkg::ARB_LAST) ?
		jac_pkg::ARB_FIRST : addr_o + 8'h01;
	// Start takes the base address, a command the given one, a lost contest the next one in the ARB_FIRST to ARB_LAST range
	wire  [7:0]       next_addr = start_i ? base_addr_i : cmd_i ? cmd_addr_i : lose ? arb_nxt : addr_o;

	// Claim state and address; a quiet wait after each claim makes it ours
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state  <= CL_IDLE;
			tmr    <= '0;
			addr_o <= jac_pkg::DEF_ADDR;
		end else begin
			addr_o <= next_addr;
			if (send) begin
				state <= CL_WAIT;
				tmr   <= '0;
			end else if (state == CL_WAIT) begin
				if (tmr == TW'(CLAIM_CYCLES - 1))
					state <= CL_DONE;
				else
					tmr <= tmr + 1'b1;
			end
		end
	end

	// Claim frame out, name as data, sent to the global address
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_req_o  <= 1'b0;
			tx_id_o   <= '0;
			tx_data_o <= '0;
		end else begin
			tx_req_o <= send;
			if (send) begin
				tx_id_o   <= jac_pkg::make_id(jac_pkg::PRIO_CLAIM,
					jac_pkg::PGN_ADDR_CLAIM | {10'h000, jac_pkg::GLOBAL_ADDR}, next_addr);
				tx_data_o <= jac_pkg::NODE_NAME;
			end
		end
	end

	assign claimed_o = state == CL_DONE;

	lose_move_a: assert property (@(posedge clk) disable iff (!rst_n)
		lose && !start_i && !cmd_i |=> tx_req_o && addr_o != $past(addr_o) && !claimed_o)
		else $error("Lost address contest without moving to a new address");

endmodule

// ### hdl/jac_command_port.sv
// Actuator command port: frame decode, address selection, sleep and wake,
// control frame fields, current trip and motor drive outputs.
// Function
// - Take group 61184 commands, 126720 feedback, handle claim and commanded address.
// - Node name defaults: arbitrary capable, function 255, zero fields, fixed maker and identity.
// - Claim address 19 by default.
// - On losing an address contest, keep trying other addresses until one sticks.
// - Adopt the address given by a commanded-address frame naming this node.
// - Three select inputs add 0 to 7 to the default address.
// - Sleep after 5 s with no bus activity.
// - On activity during sleep, wake, then send an address claim.
// - Control fields packed LSB first: position, current, speed, enable, factory bits.
// - Position is the next target, 0.1 mm per count.
// - Target reached when measured position is inside a deadband.
// - Current above limit for over 50 ms stops motion and brakes.
// - No current trip during the motor start phase.
// - Current limit below 1.0 A or above unit maximum is a parameter error.
// - Speed field sets PWM duty at 5 % per count.
// - Enable low: no motion, fields still latched.
// - Enable high starts motion with the frame's fields.
// - After overload, motion refused until a frame clears enable.
// Assumes a CAN controller delivers whole received frames as one-cycle pulses
// and sends each TX_REQ_O frame; measured position and current arrive sampled.
`timescale 1ns/100ps
module jac_command_port #(
	parameter int unsigned SLEEP_CYCLES = jac_pkg::SLEEP_CYC,
	parameter int unsigned TRIP_CYCLES  = jac_pkg::TRIP_CYC,
	parameter int unsigned START_CYCLES = jac_pkg::START_CYC,
	parameter int unsigned WAKE_CYCLES  = jac_pkg::WAKE_CYC,
	parameter int unsigned CLAIM_CYCLES = jac_pkg::CLAIM_CYC
) (
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	input  wire logic        RX_VALID_I,
	input  wire logic [28:0] RX_ID_I,
	input  wire logic [63:0] RX_DATA_I,
	input  wire logic [7:0]  RX_XBYTE_I,
	input  wire logic        BUS_ACT_I,
	input  wire logic [2:0]  ADDR_SEL_I,
	input  wire logic        VOLT24_I,
	input  wire logic [13:0] POS_MEAS_I,
	input  wire logic [8:0]  CUR_MEAS_I,
	output logic             TX_REQ_O,
	output logic      [28:0] TX_ID_O,
	output logic      [63:0] TX_DATA_O,
	output logic      [28:0] FB_ID_O,
	output logic             MOTOR_RUN_O,
	output logic             MOTOR_EXT_O,
	output logic             PWM_O,
	output logic             BRAKE_O,
	output logic             SLEEP_O,
	output logic             PARAM_ERR_O,
	output logic             OVERLOAD_O
);
	localparam int TW = jac_pkg::TMR_W;

	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} jac_pwr_e;

	jac_pwr_e      pwr;
	jac_pwr_e      next_pwr;
	logic [TW-1:0] pwr_cnt;
	logic          init_done;
	logic          sleep_en;
	logic [13:0]   pend_pos;
	logic [8:0]    pend_cur;
	logic [4:0]    pend_spd;
	logic [13:0]   act_pos;
	logic [8:0]    act_cur;
	logic [4:0]    act_spd;
	logic          en_reg;
	logic [TW-1:0] start_cnt;
	logic [TW-1:0] trip_cnt;
	logic [4:0]    pwm_cnt;
	logic [7:0]    sa;
	logic          claimed;

	// Target within deadband of the measured position
	function automatic logic in_band(input logic [13:0] meas, input logic [13:0] tgt);
		return ((meas > tgt) ? meas - tgt : tgt - meas) <= jac_pkg::DEADBAND;
	endfunction

	// Frame classification
	wire [17:0] rx_pgn   = jac_pkg::pgn_of(RX_ID_I);
	wire [7:0]  rx_da    = RX_ID_I[15:8];
	wire        awake    = pwr == PWR_RUN;
	wire        to_us    = rx_da == sa || rx_da == jac_pkg::GLOBAL_ADDR;
	wire        is_ctrl  = RX_VALID_I && awake && claimed && to_us && rx_pgn == jac_pkg::PGN_PROP_A;
	wire        is_claim = RX_VALID_I && rx_pgn == jac_pkg::PGN_ADDR_CLAIM && RX_ID_I[7:0] == sa;
	wire        is_cmd   = RX_VALID_I && rx_pgn == jac_pkg::PGN_CMD_ADDR && RX_DATA_I == jac_pkg::NODE_NAME;
	wire        activity = BUS_ACT_I || RX_VALID_I;

	// Control frame fields, factory bits ignored
	wire [13:0] f_pos = RX_DATA_I[jac_pkg::POS_LSB +: jac_pkg::POS_W];
	wire [8:0]  f_cur = RX_DATA_I[jac_pkg::CUR_LSB +: jac_pkg::CUR_W];
	wire [4:0]  f_spd = RX_DATA_I[jac_pkg::SPD_LSB +: jac_pkg::SPD_W];
	wire        f_en  = RX_DATA_I[jac_pkg::EN_BIT];

	// Parameter checks; the current ceiling depends on the supply class
	wire [8:0]  cur_max   = VOLT24_I ? jac_pkg::CUR_MAX24 : jac_pkg::CUR_MAX12;
	wire        cur_bad   = f_cur < jac_pkg::CUR_MIN || f_cur > cur_max;
	wire        range_bad = f_pos > jac_pkg::POS_MAX || f_spd > jac_pkg::SPD_MAX;
	wire        param_bad = cur_bad || range_bad;

	// Address selection: select inputs add to the default
	wire [7:0]  base_addr = jac_pkg::DEF_ADDR + {5'h00, ADDR_SEL_I};

	// Power sequencing events
	wire        idle_out  = pwr == PWR_RUN && sleep_en && !activity && pwr_cnt == TW'(SLEEP_CYCLES - 1);
	wire        wake_done = pwr == PWR_WAKE && pwr_cnt == TW'(WAKE_CYCLES - 1);
	wire        reclaim   = WR_I && ADDR_I == jac_pkg::REG_CTRL && WDATA_I[jac_pkg::CTRL_RECLAIM];
	wire        claim_go  = !init_done || wake_done || reclaim;

	// Motion control terms
	wire        reached   = in_band(POS_MEAS_I, act_pos);
	wire        load_act  = is_ctrl && f_en && !param_bad && !OVERLOAD_O;
	// Decide on the target being loaded now, so a retarget never runs a cycle on the old one
	wire [13:0] next_tgt  = load_act ? f_pos : act_pos;
	wire        next_near = in_band(POS_MEAS_I, next_tgt);
	wire        over      = MOTOR_RUN_O && start_cnt == '0 && CUR_MEAS_I > act_cur;
	wire        trip_now  = over && trip_cnt == TW'(TRIP_CYCLES);
	wire        next_perr = is_ctrl ? param_bad : PARAM_ERR_O;
	wire        next_ovl  = trip_now || (OVERLOAD_O && !(is_ctrl && !f_en));
	wire        next_en   = is_ctrl ? f_en : en_reg;
	wire        run_ok    = next_en && !next_perr && !next_ovl && awake && next_pwr == PWR_RUN && claimed &&
		!next_near;

	// Next power state
	always_comb begin
		next_pwr = pwr;
		unique case (pwr)
			PWR_RUN:   if (idle_out) next_pwr = PWR_SLEEP;
			PWR_SLEEP: if (activity) next_pwr = PWR_WAKE;
			PWR_WAKE:  if (wake_done) next_pwr = PWR_RUN;
		endcase
	end

	// Power state and its timer; any bus traffic restarts the idle count
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			pwr       <= PWR_RUN;
			pwr_cnt   <= '0;
			init_done <= 1'b0;
		end else begin
			pwr       <= next_pwr;
			init_done <= 1'b1;
			if (next_pwr != pwr || (pwr == PWR_RUN && activity) || pwr == PWR_SLEEP)
				pwr_cnt <= '0;
			else
				pwr_cnt <= pwr_cnt + 1'b1;
		end
	end

	// Latest fields are kept even while motion is disabled
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			pend_pos <= '0;
			pend_cur <= '0;
			pend_spd <= '0;
			en_reg   <= 1'b0;
		end else if (is_ctrl) begin
			pend_pos <= f_pos;
			pend_cur <= f_cur;
			pend_spd <= f_spd;
			en_reg   <= f_en;
		end
	end

	// Active move set, taken only from a clean enabled frame
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			act_pos <= '0;
			act_cur <= jac_pkg::CUR_MIN;
			act_spd <= '0;
		end else if (load_act) begin
			act_pos <= f_pos;
			act_cur <= f_cur;
			act_spd <= f_spd;
		end
	end

	// Start-phase blanking and consecutive over-current count
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			start_cnt <= TW'(START_CYCLES);
			trip_cnt  <= '0;
		end else begin
			start_cnt <= !MOTOR_RUN_O ? TW'(START_CYCLES) : (start_cnt != '0) ? start_cnt - 1'b1 : start_cnt;
			trip_cnt  <= (over && !trip_now) ? trip_cnt + 1'b1 : '0;
		end
	end

	// Twenty-step PWM frame so one speed count is 5 % duty
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I)
			pwm_cnt <= '0;
		else
			pwm_cnt <= (pwm_cnt == jac_pkg::PWM_STEPS - 5'h01) ? 5'h00 : pwm_cnt + 5'h01;
	end

	// Motor and status outputs; brake holds for as long as the overload lock
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			MOTOR_RUN_O <= 1'b0;
			MOTOR_EXT_O <= 1'b0;
			PWM_O       <= 1'b0;
			BRAKE_O     <= 1'b0;
			SLEEP_O     <= 1'b0;
			PARAM_ERR_O <= 1'b0;
			OVERLOAD_O  <= 1'b0;
		end else begin
			MOTOR_RUN_O <= run_ok;
			MOTOR_EXT_O <= next_tgt > POS_MEAS_I;
			PWM_O       <= run_ok && pwm_cnt < act_spd;
			BRAKE_O     <= next_ovl;
			SLEEP_O     <= next_pwr == PWR_SLEEP;
			PARAM_ERR_O <= next_perr;
			OVERLOAD_O  <= next_ovl;
		end
	end

	// Feedback identifier follows the claimed source address
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I)
			FB_ID_O <= '0;
		else
			FB_ID_O <= jac_pkg::make_id(jac_pkg::PRIO_FB, jac_pkg::PGN_PROP_A2, sa);
	end

	// Register read mux; unmapped addresses read zero
	wire [31:0] rd_mux =
		(ADDR_I == jac_pkg::REG_STATUS) ? {26'h0000000, reached, PARAM_ERR_O, OVERLOAD_O,
			MOTOR_RUN_O, SLEEP_O, claimed} :
		(ADDR_I == jac_pkg::REG_ADDR)   ? {24'h000000, sa} :
		(ADDR_I == jac_pkg::REG_CTRL)   ? {31'h00000000, sleep_en} :
		(ADDR_I == jac_pkg::REG_TARGET) ? {4'h0, pend_spd, pend_cur, pend_pos} : 32'h00000000;

	// Software port; read data stands only in the cycle after the strobe
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			RDATA_O  <= '0;
			sleep_en <= 1'b1;
		end else begin
			RDATA_O <= RD_I ? rd_mux : 32'h00000000;
			if (WR_I && ADDR_I == jac_pkg::REG_CTRL)
				sleep_en <= WDATA_I[jac_pkg::CTRL_SLEEP_EN];
		end
	end

	// Address claim engine; the ninth byte of a commanded-address message is the new address
	jac_addr_claim #(
		.CLAIM_CYCLES(CLAIM_CYCLES)
	) u_claim (
		.clk        (CLK_I),
		.rst_n      (RESETN_I),
		.start_i    (claim_go),
		.base_addr_i(base_addr),
		.rx_claim_i (is_claim),
		.rx_name_i  (RX_DATA_I),
		.cmd_i      (is_cmd),
		.cmd_addr_i (RX_XBYTE_I),
		.addr_o     (sa),
		.claimed_o  (claimed),
		.tx_req_o   (TX_REQ_O),
		.tx_id_o    (TX_ID_O),
		.tx_data_o  (TX_DATA_O)
	);

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	fields_latched_a: assert property (is_ctrl |=> pend_pos == $past(f_pos) && pend_spd == $past(f_spd))
		else $error("Control fields not latched");
	low_current_a: assert property (is_ctrl && f_cur < jac_pkg::CUR_MIN |=> PARAM_ERR_O && !MOTOR_RUN_O)
		else $error("Low current limit not flagged");
	range_error_a: assert property (is_ctrl && f_spd > jac_pkg::SPD_MAX |=> PARAM_ERR_O && !MOTOR_RUN_O)
		else $error("Out-of-range speed not flagged");
	enable_low_a: assert property (is_ctrl && !f_en |=> !MOTOR_RUN_O && !PWM_O)
		else $error("Motion while enable is low");
	trip_brake_a: assert property (trip_now |=> OVERLOAD_O && BRAKE_O && !MOTOR_RUN_O)
		else $error("Trip did not stop and brake");
	start_blank_a: assert property (MOTOR_RUN_O && start_cnt != '0 |-> trip_cnt == '0)
		else $error("Current trip counted during start phase");
	overload_hold_a: assert property (OVERLOAD_O && !(is_ctrl && !f_en) |=> OVERLOAD_O && !MOTOR_RUN_O)
		else $error("Overload released without enable cleared");
	sleep_entry_a: assert property (idle_out |=> SLEEP_O && !MOTOR_RUN_O)
		else $error("No sleep after idle time");
	wake_claim_a: assert property (wake_done |=> TX_REQ_O && TX_ID_O[7:0] == $past(base_addr))
		else $error("Wake not followed by address claim");
	cmd_addr_a: assert property (is_cmd && !claim_go |=> sa == $past(RX_XBYTE_I))
		else $error("Commanded address not adopted");

	move_c: cover property (load_act ##1 MOTOR_RUN_O);
	trip_c: cover property (trip_now ##1 OVERLOAD_O);
	sleep_wake_c: cover property (SLEEP_O ##1 !SLEEP_O);
	contest_c: cover property (is_claim);

endmodule

// ### sim/jac_host_model.sv
// Host controller model: sends frames and bus activity towards the node.
// Assumes the bench calls its tasks on the clock given here.
`timescale 1ns/100ps
module jac_host_model (
	input  wire logic        clk_i,
	output logic             rx_valid_o,
	output logic      [28:0] rx_id_o,
	output logic      [63:0] rx_data_o,
	output logic      [7:0]  rx_xbyte_o,
	output logic             bus_act_o
);
	// Quiet bus; one node only, so the selected address clashes only when the bench sends a rival claim
	initial begin
		rx_valid_o = 1'b0;
		rx_id_o    = '0;
		rx_data_o  = '0;
		rx_xbyte_o = '0;
		bus_act_o  = 1'b0;
	end

	// One-cycle frame; lines then show the inverse so stale data never passes as fresh
	task automatic send(input logic [28:0] id, input logic [63:0] d, input logic [7:0] xb);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_id_o    <= id;
		rx_data_o  <= d;
		rx_xbyte_o <= xb;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_id_o    <= ~id;
		rx_data_o  <= ~d;
		rx_xbyte_o <= ~xb;
	endtask

	// Control frame, factory bits all ones; speeds kept at 4 counts or more
	task automatic ctrl(input logic [7:0] sa, input logic [13:0] pos, input logic [8:0] cur,
		input logic [4:0] spd, input logic en);
		send({3'h6, 2'h0, 8'hef, sa, 8'h20}, {{35{1'b1}}, en, spd, cur, pos}, 8'h00);
	endtask

	// Bus activity without a frame
	task automatic wake;
		@(posedge clk_i);
		bus_act_o <= 1'b1;
		@(posedge clk_i);
		bus_act_o <= 1'b0;
	endtask
endmodule

// ### sim/jac_command_port_tb_top.sv
// Bench for the actuator command port: register tasks, host model and checks.
// Assumes shortened count parameters so every timed behaviour fits a short run.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module jac_command_port_tb_top;
	localparam int CLAIM = 16;
	int          n_fail  = 0;
	int          n_tests = 0;
	logic        clk, resetn, wr_st, rd_st, volt24, rx_valid, bus_act, tx_req;
	logic        run, ext, pwm, brake, sleep, perr, ovl;
	logic [7:0]  addr, rx_xbyte, sa;
	logic [2:0]  sel;
	logic [31:0] wdata, rdata, q, k;
	logic [28:0] rx_id, tx_id, fb_id;
	logic [63:0] rx_data, tx_data;
	logic [13:0] pos_meas;
	logic [8:0]  cur_meas;
	// Refused parameter sets: low current, 12 V max, 24 V max, position, speed
	logic [13:0] tp [5] = '{14'h0064, 14'h0064, 14'h0064, 14'h2711, 14'h0064};
	logic [8:0]  tc [5] = '{9'h009, 9'h0fb, 9'h07e, 9'h032, 9'h032};
	logic [4:0]  ts [5] = '{5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h15};
	logic        tv [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

	jac_command_port #(.SLEEP_CYCLES(200), .TRIP_CYCLES(20), .START_CYCLES(10), .WAKE_CYCLES(8),
		.CLAIM_CYCLES(CLAIM)) u_dut (
		.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_st), .RD_I(rd_st),
		.RDATA_O(rdata), .RX_VALID_I(rx_valid), .RX_ID_I(rx_id), .RX_DATA_I(rx_data),
		.RX_XBYTE_I(rx_xbyte), .BUS_ACT_I(bus_act), .ADDR_SEL_I(sel), .VOLT24_I(volt24),
		.POS_MEAS_I(pos_meas), .CUR_MEAS_I(cur_meas), .TX_REQ_O(tx_req), .TX_ID_O(tx_id),
		.TX_DATA_O(tx_data), .FB_ID_O(fb_id), .MOTOR_RUN_O(run), .MOTOR_EXT_O(ext), .PWM_O(pwm),
		.BRAKE_O(brake), .SLEEP_O(sleep), .PARAM_ERR_O(perr), .OVERLOAD_O(ovl)
	);

	jac_host_model u_host (
		.clk_i(clk), .rx_valid_o(rx_valid), .rx_id_o(rx_id), .rx_data_o(rx_data),
		.rx_xbyte_o(rx_xbyte), .bus_act_o(bus_act)
	);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic give_verdict;
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Register bus: one-cycle strobes, read data only in the cycle after
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_st <= 1'b1;
		@(posedge clk);
		wr_st <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		addr  <= a;
		rd_st <= 1'b1;
		@(posedge clk);
		rd_st <= 1'b0;
		#10;
		q = rdata;
	endtask

	// Watch the edge just passed and a fixed span after it for a claim frame request
	task automatic wait_tx(input int n);
		logic s;
		s = 1'b0;
		#1;
		if (tx_req === 1'b1) s = 1'b1;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (tx_req === 1'b1) s = 1'b1;
		end
		`CHK("tx req", 1'b1, s)
	endtask

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		#2000000;
		n_fail++;
		give_verdict;
	end

	initial begin
		resetn   = 1'b0;
		addr     = '0;
		wdata    = '0;
		wr_st    = 1'b0;
		rd_st    = 1'b0;
		sel      = 3'h5;
		volt24   = 1'b0;
		pos_meas = '0;
		cur_meas = '0;
		sa       = 8'h18;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("claim req", 1'b1, tx_req)
		`CHK("claim id", {3'h6, 2'h0, 8'hee, 8'hff, sa}, tx_id)
		`CHK("name", 32'h8000ff00, tx_data[63:32])
		repeat (CLAIM + 8) @(posedge clk);
		reg_rd(8'h04);
		`CHK("addr", {24'h0, sa}, q)
		`CHK("fb id", {3'h6, 18'h1ef00, sa}, fb_id)
		reg_rd(8'h00);
		`CHK("status", 5'h01, q[4:0])
		reg_rd(8'h08);
		`CHK("ctrl", 32'h1, q)
		reg_rd(8'h10);
		`CHK("unmapped", 32'h0, q)
		// Fields latch while enable is low, then motion starts
		u_host.ctrl(sa, 14'h0064, 9'h032, 5'h0a, 1'b0);
		#10;
		`CHK("idle", 1'b0, run)
		reg_rd(8'h0c);
		`CHK("fields", {4'h0, 5'h0a, 9'h032, 14'h0064}, q)
		u_host.ctrl(sa, 14'h0064, 9'h032, 5'h0a, 1'b1);
		#10;
		`CHK("run", 1'b1, run)
		`CHK("extend", 1'b1, ext)
		k = '0;
		repeat (20) begin
			@(posedge clk);
			#1;
			k = k + pwm;
		end
		`CHK("pwm", 32'h0a, k)
		@(posedge clk);
		pos_meas <= 14'h0062;
		repeat (3) @(posedge clk);
		#1;
		`CHK("deadband", 1'b0, run)
		reg_rd(8'h00);
		`CHK("reached", 1'b1, q[5])
		u_host.ctrl(sa, 14'h0064, 9'h032, 5'h0a, 1'b0);
		pos_meas <= 14'h0000;
		// Refused parameter sets
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			volt24 <= tv[i];
			u_host.ctrl(sa, tp[i], tc[i], ts[i], 1'b1);
			#10;
			`CHK("param err", 1'b1, perr)
			`CHK("no run", 1'b0, run)
		end
		@(posedge clk);
		volt24 <= 1'b0;
		u_host.ctrl(sa, 14'h2710, 9'h0fa, 5'h14, 1'b0);
		#10;
		`CHK("param ok", 1'b0, perr)
		// Overcurrent trip, start phase excluded
		@(posedge clk);
		cur_meas <= 9'h03c;
		u_host.ctrl(sa, 14'h01f4, 9'h032, 5'h0a, 1'b1);
		repeat (26) @(posedge clk);
		#1;
		`CHK("start phase", 1'b0, ovl)
		repeat (14) @(posedge clk);
		#1;
		`CHK("trip", 1'b1, ovl)
		`CHK("brake", 1'b1, brake)
		`CHK("stopped", 1'b0, run)
		@(posedge clk);
		cur_meas <= 9'h000;
		u_host.ctrl(sa, 14'h01f4, 9'h032, 5'h0a, 1'b1);
		#10;
		`CHK("locked", 1'b0, run)
		u_host.ctrl(sa, 14'h01f4, 9'h032, 5'h0a, 1'b0);
		#10;
		`CHK("unlock", 1'b0, ovl)
		u_host.ctrl(sa, 14'h01f4, 9'h032, 5'h0a, 1'b1);
		#10;
		`CHK("rerun", 1'b1, run)
		u_host.ctrl(sa, 14'h01f4, 9'h032, 5'h0a, 1'b0);
		// Lost contention, then commanded address
		u_host.send({3'h6, 2'h0, 8'hee, 8'hff, sa}, 64'h0, 8'h00);
		wait_tx(4);
		reg_rd(8'h04);
		`CHK("moved addr", 32'h80, q)
		u_host.send({3'h6, 2'h0, 8'hfe, 8'hd8, 8'h21}, jac_pkg::NODE_NAME, 8'h42);
		wait_tx(4);
		reg_rd(8'h04);
		`CHK("cmd addr", 32'h42, q)
		// Sleep on silence, wake on activity
		repeat (210) @(posedge clk);
		#1;
		`CHK("asleep", 1'b1, sleep)
		u_host.wake();
		repeat (2) @(posedge clk);
		#1;
		`CHK("awake", 1'b0, sleep)
		wait_tx(14);
		reg_wr(8'h08, 32'h2);
		wait_tx(1);
		`CHK("reclaim sa", sa, tx_id[7:0])
		repeat (250) @(posedge clk);
		reg_rd(8'h08);
		`CHK("ctrl off", 32'h0, q)
		`CHK("no sleep", 1'b0, sleep)
		give_verdict;
	end
endmodule
